// >>> shared/dram_host_pkg.sv
// Constants, timing counts and state type shared by the multiplexed-address DRAM host controller.
package dram_host_pkg;
   // ***********************************************************************
   // Device timing in nanoseconds (pause in microseconds, refresh period in milliseconds), worst speed grade
   // ***********************************************************************
   localparam int CLK_NS = 40;
   localparam int RP_NS = 100;
   localparam int RAS_MIN_NS = 150;
   localparam int CAS_MIN_NS = 75;
   localparam int CAC_NS = 75;
   localparam int WP_NS = 45;
   localparam int CP_NS = 60;
   localparam int RAS_MAX_NS = 10000;
   localparam int PAUSE_US = 100;
   localparam int REF_PERIOD_MS = 2;

   // ***********************************************************************
   // Cycle counts at the reference clock rate
   // ***********************************************************************
   localparam int RP_CYC = (RP_NS + CLK_NS - 1) / CLK_NS;
   localparam int RAS_MIN_CYC = (RAS_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int CAS_MIN_CYC = (CAS_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int CAC_CYC = (CAC_NS + CLK_NS - 1) / CLK_NS;
   localparam int WP_CYC = (WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int CP_CYC = (CP_NS + CLK_NS - 1) / CLK_NS;
   localparam int RAS_MAX_CYC = RAS_MAX_NS / CLK_NS;
   localparam int PAUSE_CYC = (PAUSE_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int REF_PERIOD_CYC = REF_PERIOD_MS * 1000000 / CLK_NS;
   localparam int SYNC_LAT = 4;
   localparam int CAS_RD_CYC = CAC_CYC + SYNC_LAT + 1;
   localparam int PAGE_MARGIN = 24;
   localparam int REF_SLACK = 32;

   // ***********************************************************************
   // Geometry and counter widths
   // ***********************************************************************
   localparam int ADDR_W = 16;
   localparam int ROW_W = 8;
   localparam int REF_ROWS = 128;
   localparam int REF_ROW_W = 7;
   localparam int INIT_CYCLES = 8;
   localparam int TM_W = 12;
   localparam int RCNT_W = 9;
   localparam int INIT_W = 4;

   localparam logic [TM_W-1:0] TM_PAUSE = TM_W'(PAUSE_CYC - 1);
   localparam logic [TM_W-1:0] TM_RP = TM_W'(RP_CYC - 1);
   localparam logic [TM_W-1:0] TM_CP = TM_W'(CP_CYC - 1);
   localparam logic [TM_W-1:0] TM_WP = TM_W'(WP_CYC - 1);
   localparam logic [TM_W-1:0] TM_CAS_RD = TM_W'(CAS_RD_CYC - 1);
   localparam logic [TM_W-1:0] TM_CAS_WR = TM_W'(CAS_MIN_CYC - 1);
   localparam logic [TM_W-1:0] TM_ONE = 12'h001;
   localparam logic [RCNT_W-1:0] RCNT_RAS_MIN = RCNT_W'(RAS_MIN_CYC - 1);
   localparam logic [RCNT_W-1:0] RCNT_PAGE_LIMIT = RCNT_W'(RAS_MAX_CYC - PAGE_MARGIN);
   localparam logic [RCNT_W-1:0] RCNT_ONE = 9'h001;
   localparam logic [RCNT_W-1:0] RCNT_MAX = 9'h1ff;
   localparam logic [INIT_W-1:0] INIT_LOAD = INIT_W'(INIT_CYCLES);
   localparam logic [INIT_W-1:0] INIT_ONE = 4'h1;
   localparam logic [REF_ROW_W-1:0] REF_ROW_ONE = 7'h01;

   typedef enum logic [3:0] {
      ST_PAUSE, ST_IDLE, ST_RAS, ST_RFSH, ST_COL, ST_CAS, ST_WE, ST_END, ST_PAGE, ST_HPRE, ST_HRAS, ST_PRE
   } state_t;
endpackage

// >>> core/pin_sync.sv
// Three-stage input synchroniser that accepts a new level once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic ref_clk, // System clock.
   input wire logic rst_n, // Asynchronous reset, active low.
   input wire logic [WIDTH-1:0] pin_in, // Raw level from outside the clock domain.
   output logic [WIDTH-1:0] level_out // Filtered level.
);
   logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
   logic [WIDTH-1:0] s1_next, s2_next, s3_next, lvl_next;

   always_comb begin
      s1_next = pin_in;
      s2_next = s1_reg;
      s3_next = s2_reg;
      // A bit whose two late stages disagree keeps its previous level.
      lvl_next = (s2_reg & s3_reg) | (lvl_reg & (s2_reg ^ s3_reg));
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         lvl_reg <= '0;
      end else begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
         s3_reg <= s3_next;
         lvl_reg <= lvl_next;
      end
   end

   assign level_out = lvl_reg;
endmodule
`default_nettype wire

// >>> core/dram_host_ctrl.sv
// Host controller that drives a 64K x 1 multiplexed-address DRAM through its strobe pins.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - 16-bit address goes out as an 8-bit row, then an 8-bit column.
// - Row strobed with column strobe high, then column address strobed.
// - Cycle ends with both strobes high; row strobe stays high for precharge.
// - Never end a cycle before minimum row and column strobe widths.
// - Read keeps write strobe high; output floats until data is valid.
// - Write data is valid by the later of write or column strobe fall.
// - Early write drops write strobe before column strobe; output floats.
// - Read-modify-write drops write strobe after column strobe; old data shows.
// - Every row is refreshed within each 2 ms interval.
// - Refresh strobes a row address with the column strobe high.
// - Hidden refresh keeps column strobe low and cycles the row strobe.
// - Page mode keeps the row open and strobes further columns.
// - After power-up wait a pause, then issue 8 row strobe cycles.
// - After 2 ms without row strobe activity, issue eight cycles again.
// - Any row strobe pulse counts as an initialization cycle.
// - Refresh walks all 128 row addresses within the refresh period.
module dram_host_ctrl #(
   parameter int REF_PERIOD_CYC = dram_host_pkg::REF_PERIOD_CYC,
   parameter int IDLE_LIMIT_CYC = dram_host_pkg::REF_PERIOD_CYC
) (
   input wire logic ref_clk, // 25 MHz system clock.
   input wire logic rst_n, // Asynchronous reset, active low.
   input wire logic req_valid, // Access request present.
   input wire logic req_write, // Request writes the bit.
   input wire logic req_rmw, // Request reads the old bit, then writes.
   input wire logic [dram_host_pkg::ADDR_W-1:0] req_addr, // Row in the high byte, column in the low byte.
   input wire logic req_wdata, // Bit to write.
   output logic req_ready, // Request taken when high with req_valid.
   output logic rsp_valid, // One-cycle pulse with read data.
   output logic rsp_data, // Bit read from the cell.
   output logic ras_n, // Row strobe, active low.
   output logic cas_n, // Column strobe, active low.
   output logic we_n, // Write strobe, active low.
   output logic [dram_host_pkg::ROW_W-1:0] mux_addr_pins, // Multiplexed address.
   output logic dram_d, // Data into the device.
   input wire logic dram_q // Data out of the device.
);
   localparam int REF_W = $clog2(REF_PERIOD_CYC + 1);
   localparam int IDLE_W = $clog2(IDLE_LIMIT_CYC + 1);
   localparam logic [REF_W-1:0] REF_LAST = REF_W'(REF_PERIOD_CYC / dram_host_pkg::REF_ROWS
                                                 - dram_host_pkg::REF_SLACK - 1);
   localparam logic [REF_W-1:0] REF_ONE = REF_W'(1);
   localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_W'(IDLE_LIMIT_CYC - 1);
   localparam logic [IDLE_W-1:0] IDLE_ONE = IDLE_W'(1);

   // ***********************************************************************
   // State
   // ***********************************************************************
   dram_host_pkg::state_t st_reg, st_next;
   logic [dram_host_pkg::TM_W-1:0] tm_reg, tm_next;
   logic [dram_host_pkg::RCNT_W-1:0] ras_cnt_reg, ras_cnt_next;
   logic [REF_W-1:0] ref_tm_reg, ref_tm_next;
   logic [IDLE_W-1:0] idle_tm_reg, idle_tm_next;
   logic [dram_host_pkg::REF_ROW_W-1:0] ref_row_reg, ref_row_next;
   logic [dram_host_pkg::INIT_W-1:0] init_left_reg, init_left_next;
   logic [dram_host_pkg::ROW_W-1:0] row_reg, row_next, col_reg, col_next, addr_reg, addr_next;
   logic ras_n_reg, ras_n_next, cas_n_reg, cas_n_next, we_n_reg, we_n_next;
   logic din_reg, din_next, wdata_reg, wdata_next;
   logic wr_reg, wr_next, rmw_reg, rmw_next, is_ref_reg, is_ref_next, go_reg, go_next;
   logic ref_pend_reg, ref_pend_next, ready_reg, ready_next;
   logic rsp_valid_reg, rsp_valid_next, rsp_data_reg, rsp_data_next;
   logic take, tm_done, ras_rise, ref_fire, ref_clr, reinit, q_sync;
   logic [dram_host_pkg::ROW_W-1:0] ref_addr;

   pin_sync #(.WIDTH(1)) u_q_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .pin_in(dram_q),
      .level_out(q_sync)
   );

   // ***********************************************************************
   // Cycle sequencer and timers
   // ***********************************************************************
   always_comb begin
      st_next = st_reg;
      tm_done = (tm_reg == '0);
      tm_next = tm_done ? tm_reg : tm_reg - dram_host_pkg::TM_ONE;
      ras_n_next = ras_n_reg;
      cas_n_next = cas_n_reg;
      we_n_next = we_n_reg;
      addr_next = addr_reg;
      din_next = din_reg;
      row_next = row_reg;
      col_next = col_reg;
      wdata_next = wdata_reg;
      wr_next = wr_reg;
      rmw_next = rmw_reg;
      is_ref_next = is_ref_reg;
      go_next = go_reg;
      ref_row_next = ref_row_reg;
      ref_clr = 1'b0;
      rsp_valid_next = 1'b0;
      rsp_data_next = rsp_data_reg;
      take = req_valid && ready_reg;
      ref_addr = {1'b0, ref_row_reg};
      if (take) begin
         row_next = req_addr[dram_host_pkg::ADDR_W-1:dram_host_pkg::ROW_W];
         col_next = req_addr[dram_host_pkg::ROW_W-1:0];
         wr_next = req_write || req_rmw;
         rmw_next = req_rmw;
         wdata_next = req_wdata;
         is_ref_next = 1'b0;
      end
      unique case (st_reg)
         dram_host_pkg::ST_PAUSE: begin
            if (tm_done) begin
               st_next = dram_host_pkg::ST_IDLE;
            end
         end
         dram_host_pkg::ST_IDLE: begin
            if (take) begin
               addr_next = row_next;
               st_next = dram_host_pkg::ST_RAS;
            end else if (ref_pend_reg || init_left_reg != '0) begin
               addr_next = ref_addr;
               is_ref_next = 1'b1;
               st_next = dram_host_pkg::ST_RAS;
            end
         end
         dram_host_pkg::ST_RAS: begin
            ras_n_next = 1'b0;
            if (is_ref_reg) begin
               ref_clr = 1'b1;
               ref_row_next = ref_row_reg + dram_host_pkg::REF_ROW_ONE;
               st_next = dram_host_pkg::ST_RFSH;
            end else begin
               st_next = dram_host_pkg::ST_COL;
            end
         end
         dram_host_pkg::ST_RFSH: begin
            if (ras_cnt_reg >= dram_host_pkg::RCNT_RAS_MIN) begin
               ras_n_next = 1'b1;
               tm_next = dram_host_pkg::TM_RP;
               st_next = dram_host_pkg::ST_PRE;
            end
         end
         dram_host_pkg::ST_COL: begin
            addr_next = col_reg;
            din_next = wdata_reg;
            we_n_next = !(wr_reg && !rmw_reg);
            st_next = dram_host_pkg::ST_CAS;
         end
         dram_host_pkg::ST_CAS: begin
            if (cas_n_reg) begin
               cas_n_next = 1'b0;
               // Column strobe falls past the row-to-column limit, so data is timed from it.
               tm_next = wr_reg && !rmw_reg ? dram_host_pkg::TM_CAS_WR : dram_host_pkg::TM_CAS_RD;
            end else if (tm_done && ras_cnt_reg >= dram_host_pkg::RCNT_RAS_MIN) begin
               if (!wr_reg || rmw_reg) begin
                  rsp_data_next = q_sync;
                  rsp_valid_next = 1'b1;
               end
               if (rmw_reg) begin
                  we_n_next = 1'b0;
                  tm_next = dram_host_pkg::TM_WP;
                  st_next = dram_host_pkg::ST_WE;
               end else begin
                  st_next = dram_host_pkg::ST_END;
               end
            end
         end
         dram_host_pkg::ST_WE: begin
            if (tm_done) begin
               st_next = dram_host_pkg::ST_END;
            end
         end
         dram_host_pkg::ST_END: begin
            we_n_next = 1'b1;
            if ((!wr_reg || rmw_reg) && ref_pend_reg) begin
               // Column strobe stays low so the read bit keeps standing on the output.
               ras_n_next = 1'b1;
               addr_next = ref_addr;
               tm_next = dram_host_pkg::TM_RP;
               st_next = dram_host_pkg::ST_HPRE;
            end else begin
               cas_n_next = 1'b1;
               tm_next = dram_host_pkg::TM_CP;
               st_next = dram_host_pkg::ST_PAGE;
            end
         end
         dram_host_pkg::ST_PAGE: begin
            if (take && row_next == row_reg) begin
               st_next = dram_host_pkg::ST_COL;
            end else if (take || tm_done) begin
               go_next = take;
               ras_n_next = 1'b1;
               tm_next = dram_host_pkg::TM_RP;
               st_next = dram_host_pkg::ST_PRE;
            end
         end
         dram_host_pkg::ST_HPRE: begin
            if (tm_done) begin
               ras_n_next = 1'b0;
               ref_clr = 1'b1;
               ref_row_next = ref_row_reg + dram_host_pkg::REF_ROW_ONE;
               st_next = dram_host_pkg::ST_HRAS;
            end
         end
         dram_host_pkg::ST_HRAS: begin
            if (ras_cnt_reg >= dram_host_pkg::RCNT_RAS_MIN) begin
               ras_n_next = 1'b1;
               cas_n_next = 1'b1;
               tm_next = dram_host_pkg::TM_RP;
               st_next = dram_host_pkg::ST_PRE;
            end
         end
         dram_host_pkg::ST_PRE: begin
            if (tm_done) begin
               if (go_reg) begin
                  go_next = 1'b0;
                  addr_next = row_reg;
                  st_next = dram_host_pkg::ST_RAS;
               end else begin
                  st_next = dram_host_pkg::ST_IDLE;
               end
            end
         end
      endcase

      ras_cnt_next = ras_n_reg ? '0 :
                     (ras_cnt_reg == dram_host_pkg::RCNT_MAX ? ras_cnt_reg : ras_cnt_reg + dram_host_pkg::RCNT_ONE);
      ras_rise = !ras_n_reg && ras_n_next;
      ref_fire = (ref_tm_reg == REF_LAST);
      // The refresh timer rests during the power-up pause, since the device holds no data yet.
      ref_tm_next = (ref_fire || st_reg == dram_host_pkg::ST_PAUSE) ? '0 : ref_tm_reg + REF_ONE;
      ref_pend_next = ref_fire || (ref_pend_reg && !ref_clr);
      reinit = (idle_tm_reg == IDLE_LAST) && !ras_rise;
      idle_tm_next = (ras_rise || reinit) ? '0 : idle_tm_reg + IDLE_ONE;
      if (reinit) begin
         init_left_next = dram_host_pkg::INIT_LOAD;
      end else if (ras_rise && init_left_reg != '0) begin
         init_left_next = init_left_reg - dram_host_pkg::INIT_ONE;
      end else begin
         init_left_next = init_left_reg;
      end
      ready_next = init_left_next == '0 && !ref_pend_next && !go_next &&
                   (st_next == dram_host_pkg::ST_IDLE ||
                    (st_next == dram_host_pkg::ST_PAGE && tm_next == '0 &&
                     ras_cnt_next < dram_host_pkg::RCNT_PAGE_LIMIT));
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= dram_host_pkg::ST_PAUSE;
         tm_reg <= dram_host_pkg::TM_PAUSE;
         ras_cnt_reg <= '0;
         ref_tm_reg <= '0;
         idle_tm_reg <= '0;
         ref_row_reg <= '0;
         init_left_reg <= dram_host_pkg::INIT_LOAD;
         row_reg <= '0;
         col_reg <= '0;
         addr_reg <= '0;
         ras_n_reg <= 1'b1;
         cas_n_reg <= 1'b1;
         we_n_reg <= 1'b1;
         din_reg <= 1'b0;
         wdata_reg <= 1'b0;
         wr_reg <= 1'b0;
         rmw_reg <= 1'b0;
         is_ref_reg <= 1'b0;
         go_reg <= 1'b0;
         ref_pend_reg <= 1'b0;
         ready_reg <= 1'b0;
         rsp_valid_reg <= 1'b0;
         rsp_data_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         tm_reg <= tm_next;
         ras_cnt_reg <= ras_cnt_next;
         ref_tm_reg <= ref_tm_next;
         idle_tm_reg <= idle_tm_next;
         ref_row_reg <= ref_row_next;
         init_left_reg <= init_left_next;
         row_reg <= row_next;
         col_reg <= col_next;
         addr_reg <= addr_next;
         ras_n_reg <= ras_n_next;
         cas_n_reg <= cas_n_next;
         we_n_reg <= we_n_next;
         din_reg <= din_next;
         wdata_reg <= wdata_next;
         wr_reg <= wr_next;
         rmw_reg <= rmw_next;
         is_ref_reg <= is_ref_next;
         go_reg <= go_next;
         ref_pend_reg <= ref_pend_next;
         ready_reg <= ready_next;
         rsp_valid_reg <= rsp_valid_next;
         rsp_data_reg <= rsp_data_next;
      end
   end

   assign req_ready = ready_reg;
   assign rsp_valid = rsp_valid_reg;
   assign rsp_data = rsp_data_reg;
   assign ras_n = ras_n_reg;
   assign cas_n = cas_n_reg;
   assign we_n = we_n_reg;
   assign mux_addr_pins = addr_reg;
   assign dram_d = din_reg;

   // ***********************************************************************
   // Checks
   // ***********************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   a_cas_under_ras: assert property ($fell(cas_n_reg) |-> !ras_n_reg && $stable(addr_reg))
      else $error("column strobe fell without open row or with moving address");
   a_ras_cas_high: assert property ($fell(ras_n_reg) && !cas_n_reg |-> st_reg == dram_host_pkg::ST_HRAS)
      else $error("row strobe fell with column strobe low outside hidden refresh");
   a_ras_addr_stable: assert property ($fell(ras_n_reg) |-> $stable(addr_reg))
      else $error("address changed at row strobe fall");
   a_precharge_min: assert property ($rose(ras_n_reg) |-> ras_n_reg[*3])
      else $error("row precharge too short");
   a_ras_width_min: assert property ($fell(ras_n_reg) |-> !ras_n_reg[*4])
      else $error("row strobe pulse too short");
   a_cas_width_min: assert property ($fell(cas_n_reg) |-> !cas_n_reg[*2])
      else $error("column strobe pulse too short");
   a_early_write_order: assert property ($fell(cas_n_reg) && wr_reg && !rmw_reg |->
                                         !we_n_reg && $stable(din_reg))
      else $error("early write strobe or data late");
   a_rmw_read_first: assert property ($fell(we_n_reg) && rmw_reg |->
                                      rsp_valid_reg && !cas_n_reg && $stable(din_reg))
      else $error("read-modify-write order broken");
   a_read_we_high: assert property (rsp_valid_reg && !wr_reg |-> we_n_reg && !cas_n_reg)
      else $error("read captured with write strobe low");
   a_refresh_served: assert property ($rose(ref_pend_reg) |-> ##[1:64] !ref_pend_reg)
      else $error("refresh request not served in time");
   a_ready_after_init: assert property (ready_reg |->
                                        init_left_reg == '0 && st_reg != dram_host_pkg::ST_PAUSE)
      else $error("request accepted before initialisation");

   c_read: cover property (rsp_valid_reg && !wr_reg);
   c_rmw: cover property ($fell(we_n_reg) && rmw_reg);
   c_hidden: cover property (st_reg == dram_host_pkg::ST_HRAS);
   c_page: cover property (st_reg == dram_host_pkg::ST_PAGE && take && row_next == row_reg);
endmodule
`default_nettype wire

// >>> verification/dram_model.sv
// Behavioural 64K x 1 multiplexed-address DRAM that also flags host protocol faults.
`timescale 1ns/1ps
`default_nettype none
module dram_model #(
   parameter real REF_NS = 655360.0
) (
   input wire logic ras_n, // Row strobe, active low.
   input wire logic cas_n, // Column strobe, active low.
   input wire logic we_n, // Write strobe, active low.
   input wire logic [7:0] mux_addr_pins, // Multiplexed address.
   input wire logic d, // Data in.
   output logic q, // Data out.
   output logic fault // Sticky host timing or order fault.
);
   logic mem [0:65535];
   logic [7:0] row, col;
   logic oe, ob;
   int ninit;
   real t_up, t_dn;
   real stamp [128];
   initial begin
      oe = 1'b0;
      ob = 1'b0;
      fault = 1'b0;
      ninit = 0;
      t_up = 0.0;
      t_dn = 0.0;
   end
   // The simulator would settle a floating line at will, so an idle output shows the inverse bit.
   assign q = oe ? ob : ~ob;
   always @(negedge ras_n) begin
      row = mux_addr_pins;
      if ($realtime < 100000.0 || $realtime - t_up < 100.0) fault = 1'b1;
      if (ninit >= 8 && $realtime - stamp[row[6:0]] > REF_NS) fault = 1'b1;
      stamp[row[6:0]] = $realtime;
      t_dn = $realtime;
   end
   always @(posedge ras_n) begin
      if (t_dn > 0.0) begin
         if ($realtime - t_dn < 150.0) fault = 1'b1;
         t_up = $realtime;
         ninit = ninit + 1;
         if (ninit == 8) foreach (stamp[i]) stamp[i] = $realtime;
      end
   end
   always @(negedge cas_n) begin
      col = mux_addr_pins;
      if (ninit < 8 || ras_n !== 1'b0) fault = 1'b1;
      if (we_n === 1'b0) mem[{row, col}] = d;
      else begin
         #75;
         if (cas_n === 1'b0) begin
            ob = mem[{row, col}];
            oe = 1'b1;
         end
      end
   end
   always @(negedge we_n) if (cas_n === 1'b0) mem[{row, col}] = d;
   always @(posedge cas_n) oe = 1'b0;
endmodule
`default_nettype wire

// >>> verification/dram_host_ctrl_tb_top.sv
// Self-checking testbench for the DRAM host controller against the device model.
`timescale 1ns/1ps
`default_nettype none
module dram_host_ctrl_tb_top;
   localparam int REF_CYC = 16384;
   logic ref_clk, rst_n, req_valid, req_write, req_rmw, req_wdata, req_ready, rsp_valid, rsp_data;
   logic ras_n, cas_n, we_n, dram_d, dram_q, fault;
   logic [15:0] req_addr;
   logic [7:0] mux_addr_pins;
   int n_mismatch = 0;
   int n_tests = 0;
   int cycles = 0;
   int n_hidden = 0;
   logic [15:0] addr_tab [4] = '{16'h0000, 16'hffff, 16'ha55a, 16'h5aa5};
   dram_host_ctrl #(.REF_PERIOD_CYC(REF_CYC), .IDLE_LIMIT_CYC(2000)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
      .req_valid(req_valid), .req_write(req_write), .req_rmw(req_rmw), .req_addr(req_addr),
      .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .mux_addr_pins(mux_addr_pins), .dram_d(dram_d),
      .dram_q(dram_q));
   dram_model #(.REF_NS(REF_CYC * 40.0)) device (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
      .mux_addr_pins(mux_addr_pins), .d(dram_d), .q(dram_q), .fault(fault));
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // A row strobe that falls while the column strobe is held low is a hidden refresh.
   always @(negedge ras_n) if (cas_n === 1'b0) n_hidden++;
   // The ceiling covers init, the idle retention wait and the accesses with wide margin.
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         n_mismatch++;
         $display("[ERR] %0t run timed out", $time);
         stop_test();
      end
   end
   task automatic stop_test();
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic got, input logic exp, input string what);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask
   // ***********************************************************************
   // Access and scenario tasks
   // ***********************************************************************
   task automatic acc(input logic wr, input logic rmw, input logic [15:0] a, input logic d, output logic q);
      int n;
      n = 0;
      q = 1'bx;
      @(negedge ref_clk);
      req_valid = 1'b1;
      req_write = wr;
      req_rmw = rmw;
      req_addr = a;
      req_wdata = d;
      while (req_ready !== 1'b1 && n < 400) begin
         @(negedge ref_clk);
         n++;
      end
      @(negedge ref_clk);
      req_valid = 1'b0;
      if (n >= 400) chk(1'b0, 1'b1, "request not taken");
      else if (!wr || rmw) begin
         n = 0;
         while (rsp_valid !== 1'b1 && n < 40) begin
            @(negedge ref_clk);
            n++;
         end
         q = rsp_data;
         chk(rsp_valid, 1'b1, "no read answer");
      end
   endtask
   task automatic t_table();
      logic q;
      foreach (addr_tab[i]) acc(1'b1, 1'b0, addr_tab[i], i[0], q);
      foreach (addr_tab[i]) begin
         acc(1'b0, 1'b0, addr_tab[i], 1'b0, q);
         chk(q, i[0], "table read");
      end
   endtask
   task automatic t_page();
      logic q;
      for (int c = 0; c < 4; c++) begin
         acc(1'b1, 1'b0, {8'h3c, 8'(c)}, c[1] ^ c[0], q);
         acc(1'b0, 1'b0, {8'h3c, 8'(c)}, 1'b0, q);
         chk(q, c[1] ^ c[0], "page read");
      end
   endtask
   task automatic t_rmw();
      logic q;
      acc(1'b1, 1'b0, 16'h7e81, 1'b1, q);
      acc(1'b0, 1'b1, 16'h7e81, 1'b0, q);
      chk(q, 1'b1, "rmw old bit");
      acc(1'b0, 1'b1, 16'h7e81, 1'b1, q);
      chk(q, 1'b0, "rmw second old bit");
      acc(1'b0, 1'b0, 16'h7e81, 1'b0, q);
      chk(q, 1'b1, "read after rmw");
   endtask
   // Back-to-back reads of one row span several refresh requests, so some must be served hidden.
   task automatic t_hidden();
      logic q;
      for (int k = 0; k < 32; k++) begin
         acc(1'b0, 1'b0, addr_tab[1], 1'b0, q);
         chk(q, 1'b1, "read around hidden refresh");
      end
      chk(n_hidden != 0, 1'b1, "no hidden refresh seen");
   endtask
   // Data must survive two full refresh periods of idle time on refresh alone.
   task automatic t_retain();
      logic q;
      repeat (2 * REF_CYC) @(negedge ref_clk);
      foreach (addr_tab[i]) begin
         acc(1'b0, 1'b0, addr_tab[i], 1'b0, q);
         chk(q, i[0], "retained read");
      end
   endtask
   initial begin
      rst_n = 1'b0;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_rmw = 1'b0;
      req_addr = 16'h0000;
      req_wdata = 1'b0;
      repeat (20) @(negedge ref_clk);
      rst_n = 1'b1;
      for (int n = 0; n < 4000 && req_ready !== 1'b1; n++) @(negedge ref_clk);
      chk(req_ready, 1'b1, "init never ended");
      t_table();
      t_page();
      t_rmw();
      t_hidden();
      t_retain();
      chk(fault, 1'b0, "device protocol fault");
      stop_test();
   end
endmodule
`default_nettype wire
